// >>> mac_irq_params.svh
// constants for the mac interrupt mask and status block
`ifndef MAC_IRQ_PARAMS_SVH
`define MAC_IRQ_PARAMS_SVH

// ==========================================================
// bus geometry
`define ADDR_W 8
`define DATA_W 32

// ==========================================================
// register byte addresses
`define OFS_RX_RAW 8'h00
`define OFS_RX_MASKED 8'h04
`define OFS_RX_MASK_SET 8'h08
`define OFS_RX_MASK_CLEAR 8'h0C
`define OFS_MAC_RAW 8'h10
`define OFS_MAC_MASKED 8'h14
`define OFS_MAC_MASK_SET 8'h18
`define OFS_MAC_MASK_CLEAR 8'h1C
`define OFS_EVENT_STATUS 8'h20

// ==========================================================
// field layout
`define RX_CH 8
`define RX_W 16
`define RX_LSB 0
`define RX_MSB 7
`define RX_THR_LSB 8
`define RX_THR_MSB 15
`define MAC_W 2
`define MAC_STAT_BIT 0
`define MAC_HOST_BIT 1
`define EVT_W 18
`define EVT_MAC_LSB 16
`define EVT_MAC_MSB 17

// ==========================================================
// reset values
`define RX_MASK_RST 16'h0000
`define MAC_MASK_RST 2'h0
`define EVT_RST 18'h00000
`define RDATA_RST 32'h0000_0000

`endif

// >>> mac_irq_pkg.sv
// types shared by the mac interrupt mask and status block
`include "mac_irq_params.svh"

package mac_irq_pkg;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // ==========================================================
  // pending sources, same layout as the event status register
  typedef struct packed {
    logic [`MAC_W-1:0] mac;
    logic [`RX_CH-1:0] rx_thresh;
    logic [`RX_CH-1:0] rx;
  } pend_t;

  // ==========================================================
  // state of the event capture
  typedef struct packed {
    logic [`EVT_W-1:0] raw;
    logic [`EVT_W-1:0] sticky;
  } evt_state_t;

  // ==========================================================
  // state of the register and mask logic
  typedef struct packed {
    logic [`RX_W-1:0] rx_mask;
    logic [`MAC_W-1:0] mac_mask;
    logic [`DATA_W-1:0] rdata;
    logic irq;
  } ctl_state_t;

endpackage : mac_irq_pkg

// >>> mac_irq_event_capture.sv
// pending level capture with sticky rising-edge event flags
`timescale 1ns/1ps
`default_nettype none
`include "mac_irq_params.svh"

module mac_irq_event_capture
  import mac_irq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pending levels and write-one-to-clear
  input wire pend_t pend_in,
  input wire logic [`EVT_W-1:0] evt_clear,
  // captured state
  output logic [`EVT_W-1:0] raw_q,
  output logic [`EVT_W-1:0] sticky_q
);

  evt_state_t q;
  evt_state_t d;
  logic [`EVT_W-1:0] rise;

  // ==========================================================
  // per-bit rising edge detect
  genvar i;
  for (i = 0; i < `EVT_W; i++) begin : g_bit
    assign rise[i] = pend_in[i] & ~q.raw[i];
  end

  // set wins over a clear in the same cycle so no edge is lost
  always_comb begin
    d.raw = pend_in;
    d.sticky = (q.sticky & ~evt_clear) | rise;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{raw: `EVT_RST, sticky: `EVT_RST};
    end else begin
      q <= d;
    end
  end

  assign raw_q = q.raw;
  assign sticky_q = q.sticky;

endmodule : mac_irq_event_capture

`default_nettype wire

// >>> mac_interrupt_mask_status.sv
// mac interrupt mask and status registers with interrupt output
// Function
// - rx mask-clear bits 15..8 set to one disable channel threshold interrupts
// - rx mask-clear bits 7..0 set to one disable channel receive interrupts
// - all receive mask bits are cleared by reset
// - mac raw status bit 1 shows host error pending, ignoring its mask
// - mac raw status bit 0 shows statistics pending before masking
// - mac masked status bits 1 and 0 show pending gated by mask
// - writing one to mac mask-set bit 1 enables host error interrupt
// - writing one to mac mask-set bit 0 enables statistics interrupt
// - writing one to mac mask-clear bit 1 disables host error interrupt
// - writing one to mac mask-clear bit 0 disables statistics interrupt
// - rx mask-set shares the clear layout; ones enable, zeros do nothing
// - rx raw status shows threshold pending 15..8 and receive pending 7..0
`timescale 1ns/1ps
`default_nettype none
`include "mac_irq_params.svh"

module mac_interrupt_mask_status
  import mac_irq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire bus_req_t reg_req,
  output logic [`DATA_W-1:0] reg_rdata,
  // pending levels from receive, host error and statistics logic
  input wire pend_t pend_in,
  // interrupt
  output logic irq
);

  ctl_state_t q;
  ctl_state_t d;
  logic [`EVT_W-1:0] raw;
  logic [`EVT_W-1:0] sticky;
  logic [`EVT_W-1:0] evt_clear;
  logic [`EVT_W-1:0] enable;
  logic [`EVT_W-1:0] masked;

  // ==========================================================
  // event capture
  mac_irq_event_capture u_capture (
    .clock(clock),
    .rst_n(rst_n),
    .pend_in(pend_in),
    .evt_clear(evt_clear),
    .raw_q(raw),
    .sticky_q(sticky)
  );

  // ==========================================================
  // masking
  // masks and sticky events share one layout, so one vector gates both
  assign enable = {q.mac_mask, q.rx_mask};
  assign masked = raw & enable;
  assign evt_clear = (reg_req.wr && reg_req.addr == `OFS_EVENT_STATUS) ?
                     reg_req.wdata[`EVT_W-1:0] : `EVT_RST;

  // ==========================================================
  // register writes, read mux and interrupt
  always_comb begin
    d = q;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `OFS_RX_MASK_SET: begin
          d.rx_mask = q.rx_mask | reg_req.wdata[`RX_W-1:0];
        end
        `OFS_RX_MASK_CLEAR: begin
          d.rx_mask[`RX_THR_MSB:`RX_THR_LSB] = q.rx_mask[`RX_THR_MSB:`RX_THR_LSB] &
                                               ~reg_req.wdata[`RX_THR_MSB:`RX_THR_LSB];
          d.rx_mask[`RX_MSB:`RX_LSB] = q.rx_mask[`RX_MSB:`RX_LSB] &
                                       ~reg_req.wdata[`RX_MSB:`RX_LSB];
        end
        `OFS_MAC_MASK_SET: begin
          d.mac_mask[`MAC_HOST_BIT] = q.mac_mask[`MAC_HOST_BIT] | reg_req.wdata[`MAC_HOST_BIT];
          d.mac_mask[`MAC_STAT_BIT] = q.mac_mask[`MAC_STAT_BIT] | reg_req.wdata[`MAC_STAT_BIT];
        end
        `OFS_MAC_MASK_CLEAR: begin
          d.mac_mask[`MAC_HOST_BIT] = q.mac_mask[`MAC_HOST_BIT] & ~reg_req.wdata[`MAC_HOST_BIT];
          d.mac_mask[`MAC_STAT_BIT] = q.mac_mask[`MAC_STAT_BIT] & ~reg_req.wdata[`MAC_STAT_BIT];
        end
        default: begin
          d.rx_mask = q.rx_mask;
        end
      endcase
    end
    // read data stand for one cycle only, zero otherwise
    d.rdata = `RDATA_RST;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `OFS_RX_RAW: begin
          d.rdata[`RX_W-1:0] = raw[`RX_W-1:0];
        end
        `OFS_RX_MASKED: begin
          d.rdata[`RX_W-1:0] = masked[`RX_W-1:0];
        end
        `OFS_RX_MASK_SET, `OFS_RX_MASK_CLEAR: begin
          d.rdata[`RX_W-1:0] = q.rx_mask;
        end
        `OFS_MAC_RAW: begin
          d.rdata[`MAC_HOST_BIT] = raw[`EVT_MAC_LSB + `MAC_HOST_BIT];
          d.rdata[`MAC_STAT_BIT] = raw[`EVT_MAC_LSB + `MAC_STAT_BIT];
        end
        `OFS_MAC_MASKED: begin
          d.rdata[`MAC_W-1:0] = masked[`EVT_MAC_MSB:`EVT_MAC_LSB];
        end
        `OFS_MAC_MASK_SET, `OFS_MAC_MASK_CLEAR: begin
          d.rdata[`MAC_W-1:0] = q.mac_mask;
        end
        `OFS_EVENT_STATUS: begin
          d.rdata[`EVT_W-1:0] = sticky;
        end
        default: begin
          d.rdata = `RDATA_RST;
        end
      endcase
    end
    // level follows live masked pending and latched masked edges
    d.irq = (|masked) | (|(sticky & enable));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{rx_mask: `RX_MASK_RST, mac_mask: `MAC_MASK_RST, rdata: `RDATA_RST, irq: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq = q.irq;

  // ==========================================================
  // named sequences for the checks
  sequence s_wr_at(logic [`ADDR_W-1:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence

  sequence s_rd_at(logic [`ADDR_W-1:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  // ==========================================================
  // receive mask and raw status checks
  property p_rx_clear_thresh;
    @(posedge clock) disable iff (!rst_n)
    s_wr_at(`OFS_RX_MASK_CLEAR) |=>
      q.rx_mask[`RX_THR_MSB:`RX_THR_LSB] ==
      ($past(q.rx_mask[`RX_THR_MSB:`RX_THR_LSB]) & ~$past(reg_req.wdata[`RX_THR_MSB:`RX_THR_LSB]));
  endproperty
  a_rx_clear_thresh: assert property (p_rx_clear_thresh)
    else $error("rx threshold mask not cleared by mask-clear write");

  property p_rx_clear_chan;
    @(posedge clock) disable iff (!rst_n)
    s_wr_at(`OFS_RX_MASK_CLEAR) |=>
      q.rx_mask[`RX_MSB:`RX_LSB] ==
      ($past(q.rx_mask[`RX_MSB:`RX_LSB]) & ~$past(reg_req.wdata[`RX_MSB:`RX_LSB]));
  endproperty
  a_rx_clear_chan: assert property (p_rx_clear_chan)
    else $error("rx channel mask not cleared by mask-clear write");

  property p_reset_masks;
    @(posedge clock)
    $rose(rst_n) |-> q.rx_mask == `RX_MASK_RST && !irq;
  endproperty
  a_reset_masks: assert property (p_reset_masks)
    else $error("receive masks not clear after reset");

  property p_rx_set;
    @(posedge clock) disable iff (!rst_n)
    s_wr_at(`OFS_RX_MASK_SET) |=>
      q.rx_mask == ($past(q.rx_mask) | $past(reg_req.wdata[`RX_W-1:0]));
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("rx mask-set write did not set exactly the written ones");

  property p_rx_raw_read;
    @(posedge clock) disable iff (!rst_n)
    s_rd_at(`OFS_RX_RAW) |=>
      reg_rdata == {{(`DATA_W-`RX_W){1'b0}}, $past(raw[`RX_W-1:0])};
  endproperty
  a_rx_raw_read: assert property (p_rx_raw_read)
    else $error("rx raw status read mismatch");

  // ==========================================================
  // mac status checks
  property p_mac_raw_host;
    @(posedge clock) disable iff (!rst_n)
    s_rd_at(`OFS_MAC_RAW) |=>
      reg_rdata[`MAC_HOST_BIT] == $past(pend_in.mac[`MAC_HOST_BIT], 2);
  endproperty
  a_mac_raw_host: assert property (p_mac_raw_host)
    else $error("host error raw status does not follow its source");

  property p_mac_raw_stat;
    @(posedge clock) disable iff (!rst_n)
    s_rd_at(`OFS_MAC_RAW) |=>
      reg_rdata[`MAC_STAT_BIT] == $past(pend_in.mac[`MAC_STAT_BIT], 2) &&
      reg_rdata[`DATA_W-1:`MAC_W] == '0;
  endproperty
  a_mac_raw_stat: assert property (p_mac_raw_stat)
    else $error("statistics raw status does not follow its source");

  property p_mac_masked;
    @(posedge clock) disable iff (!rst_n)
    s_rd_at(`OFS_MAC_MASKED) |=>
      reg_rdata[`MAC_W-1:0] == ($past(raw[`EVT_MAC_MSB:`EVT_MAC_LSB]) & $past(q.mac_mask));
  endproperty
  a_mac_masked: assert property (p_mac_masked)
    else $error("mac masked status is not raw gated by mask");

  // ==========================================================
  // mac mask checks
  property p_mac_set_host;
    @(posedge clock) disable iff (!rst_n)
    s_wr_at(`OFS_MAC_MASK_SET) |=>
      q.mac_mask[`MAC_HOST_BIT] == ($past(q.mac_mask[`MAC_HOST_BIT]) | $past(reg_req.wdata[`MAC_HOST_BIT]));
  endproperty
  a_mac_set_host: assert property (p_mac_set_host)
    else $error("host error mask-set misbehaved");

  property p_mac_set_stat;
    @(posedge clock) disable iff (!rst_n)
    s_wr_at(`OFS_MAC_MASK_SET) |=>
      q.mac_mask[`MAC_STAT_BIT] == ($past(q.mac_mask[`MAC_STAT_BIT]) | $past(reg_req.wdata[`MAC_STAT_BIT]));
  endproperty
  a_mac_set_stat: assert property (p_mac_set_stat)
    else $error("statistics mask-set misbehaved");

  property p_mac_clear_host;
    @(posedge clock) disable iff (!rst_n)
    s_wr_at(`OFS_MAC_MASK_CLEAR) |=>
      q.mac_mask[`MAC_HOST_BIT] == ($past(q.mac_mask[`MAC_HOST_BIT]) & ~$past(reg_req.wdata[`MAC_HOST_BIT]));
  endproperty
  a_mac_clear_host: assert property (p_mac_clear_host)
    else $error("host error mask-clear misbehaved");

  property p_mac_clear_stat;
    @(posedge clock) disable iff (!rst_n)
    s_wr_at(`OFS_MAC_MASK_CLEAR) |=>
      q.mac_mask[`MAC_STAT_BIT] == ($past(q.mac_mask[`MAC_STAT_BIT]) & ~$past(reg_req.wdata[`MAC_STAT_BIT]));
  endproperty
  a_mac_clear_stat: assert property (p_mac_clear_stat)
    else $error("statistics mask-clear misbehaved");

  // ==========================================================
  // readback and interrupt checks
  property p_mask_readback;
    @(posedge clock) disable iff (!rst_n)
    reg_req.rd && (reg_req.addr == `OFS_MAC_MASK_SET || reg_req.addr == `OFS_MAC_MASK_CLEAR) |=>
      reg_rdata == {{(`DATA_W-`MAC_W){1'b0}}, $past(q.mac_mask)};
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("mac mask readback wrong or reserved bits nonzero");

  property p_rdata_idle;
    @(posedge clock) disable iff (!rst_n)
    !reg_req.rd |=> reg_rdata == `RDATA_RST;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");

  property p_irq_follows;
    @(posedge clock) disable iff (!rst_n)
    (|masked) |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt low while a masked bit is set");

  property p_irq_quiet;
    @(posedge clock) disable iff (!rst_n)
    (enable == '0) [*2] |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt high with every source masked");

  property p_irq_off;
    @(posedge clock) disable iff (!rst_n)
    (enable == '0) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt still high one cycle after all sources masked");

  property p_irq_sticky;
    @(posedge clock) disable iff (!rst_n)
    (|(sticky & enable)) |=> irq;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("interrupt low while an enabled event is latched");

  // ==========================================================
  // event capture, status read and rx mask readback checks
  property p_raw_follows;
    @(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> raw == $past(pend_in);
  endproperty
  a_raw_follows: assert property (p_raw_follows)
    else $error("raw pending does not follow its source by one cycle");

  property p_evt_set;
    @(posedge clock) disable iff (!rst_n)
    (|(pend_in & ~raw)) |=> (sticky & $past(pend_in & ~raw)) == $past(pend_in & ~raw);
  endproperty
  a_evt_set: assert property (p_evt_set)
    else $error("rising pending edge not latched in event status");

  property p_evt_clear;
    @(posedge clock) disable iff (!rst_n)
    s_wr_at(`OFS_EVENT_STATUS) |=>
      (sticky & $past(reg_req.wdata[`EVT_W-1:0] & ~(pend_in & ~raw))) == '0;
  endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("event status bit survived its write-one-to-clear");

  property p_evt_read;
    @(posedge clock) disable iff (!rst_n)
    s_rd_at(`OFS_EVENT_STATUS) |=>
      reg_rdata == {{(`DATA_W-`EVT_W){1'b0}}, $past(sticky)};
  endproperty
  a_evt_read: assert property (p_evt_read)
    else $error("event status read mismatch");

  property p_rx_masked_read;
    @(posedge clock) disable iff (!rst_n)
    s_rd_at(`OFS_RX_MASKED) |=>
      reg_rdata == {{(`DATA_W-`RX_W){1'b0}}, $past(raw[`RX_W-1:0] & q.rx_mask)};
  endproperty
  a_rx_masked_read: assert property (p_rx_masked_read)
    else $error("rx masked status is not raw gated by mask");

  property p_rx_mask_readback;
    @(posedge clock) disable iff (!rst_n)
    reg_req.rd && (reg_req.addr == `OFS_RX_MASK_SET || reg_req.addr == `OFS_RX_MASK_CLEAR) |=>
      reg_rdata == {{(`DATA_W-`RX_W){1'b0}}, $past(q.rx_mask)};
  endproperty
  a_rx_mask_readback: assert property (p_rx_mask_readback)
    else $error("rx mask readback wrong or reserved bits nonzero");

endmodule : mac_interrupt_mask_status

`default_nettype wire

// >>> mac_interrupt_mask_status_tb.sv
// self-checking testbench for the mac interrupt mask and status block
`timescale 1ns/1ps
`default_nettype none
`include "mac_irq_params.svh"

module mac_interrupt_mask_status_tb
  import mac_irq_pkg::*;
;
  // ==========================================================
  // signals
  logic clock;
  logic rst_n;
  bus_req_t req;
  logic [`DATA_W-1:0] rdata;
  pend_t pend;
  logic irq;
  int failures;
  int tests_run;

  mac_interrupt_mask_status mac_interrupt_mask_status_inst (
    .clock(clock),
    .rst_n(rst_n),
    .reg_req(req),
    .reg_rdata(rdata),
    .pend_in(pend),
    .irq(irq)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ==========================================================
  // bus and compare tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task chk_irq(input logic exp);
    tests_run++;
    if (irq !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, irq, exp);
    end
  endtask : chk_irq

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rchk

  // irq is two registers behind its cause, so settle a few cycles
  task idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle

  // ==========================================================
  // scenarios
  task t_reset;
    rchk(`OFS_RX_MASK_SET, 32'h0000_0000);
    rchk(`OFS_RX_MASK_CLEAR, 32'h0000_0000);
    rchk(`OFS_MAC_MASK_SET, 32'h0000_0000);
    chk_irq(1'b0);
  endtask : t_reset

  task t_rx_mask;
    wr(`OFS_RX_MASK_SET, 32'hFFFF_A5C3);
    rchk(`OFS_RX_MASK_SET, 32'h0000_A5C3);
    wr(`OFS_RX_MASK_CLEAR, 32'h0000_0000);
    rchk(`OFS_RX_MASK_CLEAR, 32'h0000_A5C3);
    wr(`OFS_RX_MASK_CLEAR, 32'hFFFF_8001);
    rchk(`OFS_RX_MASK_SET, 32'h0000_25C2);
    wr(`OFS_RX_MASK_SET, 32'h0000_0000);
    rchk(`OFS_RX_MASK_CLEAR, 32'h0000_25C2);
  endtask : t_rx_mask

  task t_rx_pend;
    @(posedge clock);
    pend <= 18'h00F0F;
    idle(3);
    rchk(`OFS_RX_RAW, 32'h0000_0F0F);
    rchk(`OFS_RX_MASKED, 32'h0000_0502);
    chk_irq(1'b1);
    // masking alone must drop irq even with sticky events still set
    wr(`OFS_RX_MASK_CLEAR, 32'h0000_0502);
    idle(3);
    chk_irq(1'b0);
    rchk(`OFS_RX_MASKED, 32'h0000_0000);
    @(posedge clock);
    pend <= 18'h00000;
    wr(`OFS_RX_MASK_CLEAR, 32'h0000_FFFF);
    wr(`OFS_EVENT_STATUS, 32'h0003_FFFF);
  endtask : t_rx_pend

  task t_mac;
    @(posedge clock);
    pend <= 18'h30000;
    idle(3);
    rchk(`OFS_MAC_RAW, 32'h0000_0003);
    rchk(`OFS_MAC_MASKED, 32'h0000_0000);
    chk_irq(1'b0);
    wr(`OFS_MAC_MASK_SET, 32'h0000_0002);
    rchk(`OFS_MAC_MASKED, 32'h0000_0002);
    rchk(`OFS_MAC_MASK_SET, 32'h0000_0002);
    chk_irq(1'b1);
    wr(`OFS_MAC_MASK_SET, 32'hFFFF_FFFD);
    rchk(`OFS_MAC_MASKED, 32'h0000_0003);
    wr(`OFS_MAC_MASK_CLEAR, 32'h0000_0002);
    rchk(`OFS_MAC_MASKED, 32'h0000_0001);
    wr(`OFS_MAC_MASK_CLEAR, 32'h0000_0000);
    rchk(`OFS_MAC_MASK_CLEAR, 32'h0000_0001);
    wr(`OFS_MAC_MASK_CLEAR, 32'h0000_0001);
    rchk(`OFS_MAC_MASKED, 32'h0000_0000);
    idle(3);
    chk_irq(1'b0);
    // raw status is read-only and an unmapped place reads zero
    wr(`OFS_MAC_RAW, 32'h0000_0000);
    rchk(`OFS_MAC_RAW, 32'h0000_0003);
    rchk(8'h40, 32'h0000_0000);
    @(posedge clock);
    pend <= 18'h00000;
    wr(`OFS_EVENT_STATUS, 32'h0003_FFFF);
  endtask : t_mac

  task t_event;
    wr(`OFS_MAC_MASK_SET, 32'h0000_0001);
    @(posedge clock);
    pend <= 18'h10000;
    @(posedge clock);
    pend <= 18'h00000;
    idle(3);
    rchk(`OFS_EVENT_STATUS, 32'h0001_0000);
    rchk(`OFS_MAC_RAW, 32'h0000_0000);
    chk_irq(1'b1);
    wr(`OFS_EVENT_STATUS, 32'h0001_0000);
    idle(3);
    chk_irq(1'b0);
    rchk(`OFS_EVENT_STATUS, 32'h0000_0000);
  endtask : t_event

  // ==========================================================
  // verdict
  task results;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    failures = 0;
    tests_run = 0;
    rst_n = 1'b0;
    req = '0;
    pend = '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_rx_mask();
    t_rx_pend();
    t_mac();
    t_event();
    results();
  end

  // the whole run needs a little over a hundred cycles
  initial begin
    #100000;
    failures++;
    results();
  end

endmodule : mac_interrupt_mask_status_tb

`default_nettype wire
